// ===== include/pfh_pkg.sv
// package for the parallel flash host controller: commands, pins, timing
package pfh_pkg;
  // address and data widths of the flash bus
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // unlock addresses and command bytes
  localparam logic [14:0] UNLOCK_ADDR_A = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_B = 15'h2AAA;
  localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
  // identification read addresses
  localparam logic [16:0] ID_MAKER_ADDR = 17'h00000;
  localparam logic [16:0] ID_PART_ADDR = 17'h00001;
  // sector select starts at address bit 12
  localparam int SECTOR_LSB = 12;
  // strobe timing: time in ns and cycles at 40 MHz (25 ns period)
  localparam int CLK_PERIOD_NS = 25;
  localparam int READ_CYCLE_NS = 70;
  localparam int WRITE_PULSE_NS = 50;
  localparam logic [3:0] READ_CYC =
    4'((READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WRITE_CYC =
    4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // operations the user may request
  typedef enum logic [2:0] {
    PFH_OP_READ = 3'h0,
    PFH_OP_PROGRAM = 3'h1,
    PFH_OP_SECTOR_ERASE = 3'h2,
    PFH_OP_CHIP_ERASE = 3'h3,
    PFH_OP_ID_ENTRY = 3'h4,
    PFH_OP_ID_EXIT = 3'h5,
    PFH_OP_ID_EXIT_LONG = 3'h6
  } pfh_op_e;
  // user request bundle
  typedef struct packed {
    pfh_op_e op;
    logic [16:0] addr;
    logic [7:0] data;
  } pfh_req_s;
  // one bus write of a command sequence
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } pfh_cyc_s;
  // flash pin bundle driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [16:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
  } pfh_pins_s;
  // controller states
  typedef enum logic [2:0] {
    PFH_IDLE = 3'h0,
    PFH_WR_SETUP = 3'h1,
    PFH_WR_PULSE = 3'h2,
    PFH_WR_HOLD = 3'h3,
    PFH_RD = 3'h4,
    PFH_DONE = 3'h5
  } pfh_state_e;
endpackage

// ===== rtl/pfh_host.sv
// host controller that drives a parallel flash through its pins
`timescale 1ns/10ps
// Behaviour
// RULE_01: program is three unlock writes then byte
// RULE_02: erase is six writes, sector or chip
// RULE_03: device aborts bad sequences to read mode
// RULE_04: no program or erase without unlock
// RULE_05: id entry is three writes ending 90H
// RULE_06: id reads at 0000H and 0001H
// RULE_07: id exit by F0H or unlock plus F0H
// RULE_08: device ignores id exit while busy
// RULE_09: device forgets id mode at power loss
// RULE_10: device matches only address bits 14..0
// RULE_11: sector chosen by bits 12 and up
// RULE_12: data lines float when gate or select high; the flash model drives the inverse of the last byte instead
// RULE_13: select and gate low reads byte
// RULE_14: write strobe low latches data lines
// RULE_15: select high means standby
// RULE_16: address on late fall, data early rise
// RULE_17: no write with gate low or select high
// RULE_18: device discards commands while programming
// RULE_19: busy reads return poll and toggle bits
// RULE_20: tracker returns idle after each sequence
module pfh_host
  import pfh_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input pfh_pkg::pfh_req_s req,
  // user answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // flash pins
  output pfh_pkg::pfh_pins_s pins,
  input wire logic [7:0] dq_i
);
  import pfh_pkg::*;

  // reset synchroniser, released through two flops
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // one bus write of an operation's sequence, by index
  function automatic pfh_cyc_s seq_cyc(input pfh_req_s r,
                                       input logic [2:0] i);
    pfh_cyc_s c;
    c.addr = {2'h0, UNLOCK_ADDR_A};
    c.data = UNLOCK_DATA_A;
    if (r.op == PFH_OP_ID_EXIT) begin
      c.addr = r.addr;  // single F0H to any address [RULE_07]
      c.data = CMD_ID_EXIT;
    end else begin
      unique case (i)
        3'h0: c = '{addr: {2'h0, UNLOCK_ADDR_A}, data: UNLOCK_DATA_A};
        3'h1: c = '{addr: {2'h0, UNLOCK_ADDR_B}, data: UNLOCK_DATA_B};
        3'h2: begin
          // third write picks the command [RULE_01] [RULE_05] [RULE_07]
          unique case (r.op)
            PFH_OP_PROGRAM: c.data = CMD_PROGRAM;
            PFH_OP_ID_ENTRY: c.data = CMD_ID_ENTRY;
            PFH_OP_ID_EXIT_LONG: c.data = CMD_ID_EXIT;
            default: c.data = CMD_ERASE_SETUP;  // [RULE_02]
          endcase
        end
        3'h3: begin
          if (r.op == PFH_OP_PROGRAM) begin
            c = '{addr: r.addr, data: r.data};  // target byte [RULE_01]
          end
        end
        3'h4: c = '{addr: {2'h0, UNLOCK_ADDR_B}, data: UNLOCK_DATA_B};
        default: begin
          if (r.op == PFH_OP_SECTOR_ERASE) begin
            // low bits cleared, sector from bit 12 up [RULE_11]
            c.addr = {r.addr[16:SECTOR_LSB], 12'h000};
            c.data = CMD_SECTOR_ERASE;  // [RULE_02]
          end else begin
            c.data = CMD_CHIP_ERASE;  // [RULE_02]
          end
        end
      endcase
    end
    return c;
  endfunction

  // number of writes in an operation, minus one
  function automatic logic [2:0] seq_last(input pfh_op_e op);
    unique case (op)
      PFH_OP_PROGRAM: return 3'h3;
      PFH_OP_SECTOR_ERASE, PFH_OP_CHIP_ERASE: return 3'h5;
      PFH_OP_ID_EXIT: return 3'h0;
      PFH_OP_READ: return 3'h0;
      default: return 3'h2;
    endcase
  endfunction

  // controller state
  pfh_state_e state_q, state_d;
  pfh_req_s req_q, req_d;
  logic [2:0] idx_q, idx_d;  // write index within the sequence
  logic [3:0] cnt_q, cnt_d;  // strobe timer
  pfh_pins_s pins_q, pins_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  pfh_cyc_s cyc;

  assign cyc = seq_cyc(req_q, idx_q);
  assign req_ready = (state_q == PFH_IDLE);
  assign pins = pins_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  // next-state logic for the pin sequencer
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    pins_d = pins_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    unique case (state_q)
      PFH_IDLE: begin
        // standby: select high, data floating [RULE_15]
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        pins_d.we_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        idx_d = 3'h0;  // each request restarts the sequence [RULE_20]
        if (req_valid) begin
          req_d = req;
          cnt_d = 4'h0;
          state_d = (req.op == PFH_OP_READ) ? PFH_RD : PFH_WR_SETUP;
        end
      end
      PFH_WR_SETUP: begin
        // gate high before write; address set [RULE_17]
        pins_d.oe_n = 1'b1;
        pins_d.ce_n = 1'b0;
        pins_d.addr = cyc.addr;
        pins_d.dq_o = cyc.data;
        pins_d.dq_oe = 1'b1;
        state_d = PFH_WR_PULSE;
        cnt_d = 4'h0;
      end
      PFH_WR_PULSE: begin
        // strobe low; address taken on fall [RULE_16] [RULE_14]
        pins_d.we_n = 1'b0;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == WRITE_CYC) begin
          pins_d.we_n = 1'b1;  // data taken on rise [RULE_16]
          state_d = PFH_WR_HOLD;
        end
      end
      PFH_WR_HOLD: begin
        // release select, then next write or finish
        pins_d.ce_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        if (idx_q == seq_last(req_q.op)) begin
          state_d = PFH_DONE;  // [RULE_04]
        end else begin
          idx_d = idx_q + 3'h1;
          state_d = PFH_WR_SETUP;
        end
      end
      PFH_RD: begin
        // select and gate low, strobe high [RULE_13]
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        pins_d.we_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        pins_d.addr = req_q.addr;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == READ_CYC) begin
          rsp_data_d = dq_i;  // array, id or status byte [RULE_19]
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          state_d = PFH_DONE;
        end
      end
      default: begin
        // answer once and go back to idle [RULE_20]
        rsp_valid_d = 1'b1;
        state_d = PFH_IDLE;
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= PFH_IDLE;
      req_q <= '0;
      idx_q <= 3'h0;
      cnt_q <= 4'h0;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  addr: 17'h00000, dq_o: 8'h00, dq_oe: 1'b0};
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // checks on the pins this host drives and on its answers
  a_no_drive_on_read: assert property (@(posedge clk_sys)  // [RULE_12]
    disable iff (!rst_n_q) !pins.oe_n |-> !pins.dq_oe)
    else $error("host drives data while gate low");
  a_write_gate_high: assert property (@(posedge clk_sys)  // [RULE_17]
    disable iff (!rst_n_q) !pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("write strobe with bad gate or select");
  a_first_unlock: assert property (@(posedge clk_sys)  // [RULE_01]
    disable iff (!rst_n_q)
    $fell(pins.we_n) && idx_q == 3'h0 && req_q.op != PFH_OP_ID_EXIT
    |-> pins.addr[14:0] == UNLOCK_ADDR_A && pins.dq_o == UNLOCK_DATA_A)
    else $error("first write is not unlock");
  a_second_unlock: assert property (@(posedge clk_sys)  // [RULE_04]
    disable iff (!rst_n_q) $fell(pins.we_n) && idx_q == 3'h1
    |-> pins.addr[14:0] == UNLOCK_ADDR_B && pins.dq_o == UNLOCK_DATA_B)
    else $error("second write is not unlock");
  a_erase_setup: assert property (@(posedge clk_sys)  // [RULE_02]
    disable iff (!rst_n_q) $fell(pins.we_n) && idx_q == 3'h2 &&
    (req_q.op == PFH_OP_SECTOR_ERASE || req_q.op == PFH_OP_CHIP_ERASE)
    |-> pins.dq_o == CMD_ERASE_SETUP)
    else $error("erase setup byte wrong");
  a_id_entry_cmd: assert property (@(posedge clk_sys)  // [RULE_05]
    disable iff (!rst_n_q) $fell(pins.we_n) && idx_q == 3'h2 &&
    req_q.op == PFH_OP_ID_ENTRY |-> pins.dq_o == CMD_ID_ENTRY)
    else $error("id entry byte wrong");
  a_id_exit_cmd: assert property (@(posedge clk_sys)  // [RULE_07]
    disable iff (!rst_n_q) $fell(pins.we_n) &&
    req_q.op == PFH_OP_ID_EXIT |-> pins.dq_o == CMD_ID_EXIT)
    else $error("id exit byte wrong");
  a_sector_addr: assert property (@(posedge clk_sys)  // [RULE_11]
    disable iff (!rst_n_q) $fell(pins.we_n) && idx_q == 3'h5 &&
    req_q.op == PFH_OP_SECTOR_ERASE |-> pins.addr[11:0] == 12'h000
    && pins.dq_o == CMD_SECTOR_ERASE)
    else $error("sector erase write wrong");
  a_read_answer: assert property (@(posedge clk_sys)  // [RULE_13]
    disable iff (!rst_n_q) $rose(state_q == PFH_RD) |->
    ##[1:8] rsp_valid)
    else $error("read answer late");
  a_back_to_idle: assert property (@(posedge clk_sys)  // [RULE_20]
    disable iff (!rst_n_q) rsp_valid |-> state_q == PFH_IDLE)
    else $error("sequencer not idle after answer");
  c_program: cover property (@(posedge clk_sys)
    state_q == PFH_DONE && req_q.op == PFH_OP_PROGRAM);
  c_sector: cover property (@(posedge clk_sys)
    state_q == PFH_DONE && req_q.op == PFH_OP_SECTOR_ERASE);
  c_id_read: cover property (@(posedge clk_sys)
    rsp_valid && req_q.op == PFH_OP_READ &&
    req_q.addr == ID_PART_ADDR);
endmodule

// ===== testbench/pfh_flash_model.sv
// behavioural model of the parallel flash seen by the host controller
`timescale 1ns/10ps
module pfh_flash_model
  import pfh_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
  parameter int BUSY_READS = 2
)
(
  // pins from the host
  input pfh_pkg::pfh_pins_s pins,
  // data lines back to the host
  output logic [7:0] dq_i
);
  logic [7:0] mem [0:131071]; // array contents
  logic [7:0] rd_byte, last_d;
  logic [16:0] a_lat;
  logic id_mode = 1'b0; // starts in read mode
  logic erase_op, tog;
  int step, busy;
  wire rd_act = !pins.ce_n && !pins.oe_n && pins.we_n;
  wire wr_act = !pins.ce_n && pins.oe_n && !pins.we_n;
  // released lines show the inverse of the last byte
  assign dq_i = rd_act ? rd_byte : ~rd_byte;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    step = 0;
    busy = 0;
    tog = 1'b1;
    rd_byte = 8'h00;
  end
  // address taken at the later falling strobe
  always @(posedge wr_act) a_lat = pins.addr;
  // data taken at the earlier rising strobe, then decoded
  always @(negedge wr_act) begin : decode
    logic [14:0] a;
    logic [7:0] d;
    a = a_lat[14:0]; // only low address bits matched
    d = pins.dq_o;
    if (busy > 0) begin
      step = 0; // commands ignored while busy
    end else if (step == 0 && d == CMD_ID_EXIT) begin
      id_mode = 1'b0; // short exit
    end else if (step == 3) begin
      mem[a_lat] = d; // program only after unlock
      last_d = d;
      erase_op = 1'b0;
      busy = BUSY_READS;
      step = 0;
    end else if (step == 6 && d == CMD_SECTOR_ERASE) begin
      for (int i = 0; i < 4096; i++) begin
        mem[{a_lat[16:12], 12'h000} + i] = 8'hFF;
      end
      erase_op = 1'b1;
      busy = BUSY_READS;
      step = 0;
    end else if (step == 6 && d == CMD_CHIP_ERASE && a == UNLOCK_ADDR_A) begin
      foreach (mem[i]) mem[i] = 8'hFF;
      erase_op = 1'b1;
      busy = BUSY_READS;
      step = 0;
    end else if ((step == 0 || step == 4) && a == UNLOCK_ADDR_A
                 && d == UNLOCK_DATA_A) begin
      step = step + 1;
    end else if ((step == 1 || step == 5) && a == UNLOCK_ADDR_B
                 && d == UNLOCK_DATA_B) begin
      step = step + 1;
    end else if (step == 2 && a == UNLOCK_ADDR_A) begin
      // third write picks the command
      if (d == CMD_ID_ENTRY) id_mode = 1'b1;
      if (d == CMD_ID_EXIT) id_mode = 1'b0;
      step = (d == CMD_PROGRAM) ? 3 : (d == CMD_ERASE_SETUP) ? 4 : 0;
    end else begin
      step = 0; // mismatch aborts to read mode
    end
  end
  // each read start picks status, id code or array byte
  always @(posedge rd_act) begin
    if (busy > 0) begin
      // poll and toggle bits while busy
      rd_byte = {erase_op ? 1'b0 : ~last_d[7], tog, 6'h00};
      tog = ~tog;
      busy = busy - 1;
    end else if (id_mode && pins.addr[16:1] == 16'h0000) begin
      rd_byte = pins.addr[0] ? PART_CODE : MAKER_CODE;
    end else begin
      rd_byte = mem[pins.addr];
      tog = 1'b1;
    end
  end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/10ps
module tb;
  import pfh_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'h5A; // arbitrary value
  logic clk_sys, reset_n, req_valid, req_ready, rsp_valid;
  logic [7:0] rsp_data, dq_i, q;
  pfh_req_s req;
  pfh_pins_s pins;
  int miscompares = 0, total_checks = 0, wr_cnt = 0;
  pfh_host i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .dq_i(dq_i));
  pfh_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_READS(2))
    i_flash (.pins(pins), .dq_i(dq_i));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // count write strobes on the wire
  always @(negedge pins.we_n) wr_cnt++;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request, waits bounded for the answer
  task automatic run_op(input pfh_op_e op, input logic [16:0] a,
                        input logic [7:0] d);
    int i;
    @(negedge clk_sys);
    wr_cnt = 0;
    req_valid = 1'b1;
    req = '{op: op, addr: a, data: d};
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    if (req_ready !== 1'b1) begin
      miscompares++;
      conclude();
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    if (rsp_valid !== 1'b1) begin
      miscompares++;
      conclude();
    end
    q = rsp_data;
  endtask
  task automatic t_program;
    run_op(PFH_OP_PROGRAM, 17'h01234, 8'h5A);
    chk(8'(wr_cnt), 8'h04);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    chk({6'h0, q[7:6]}, 8'h03);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    chk({6'h0, q[7:6]}, 8'h02);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    chk(q, 8'h5A);
    $display("test program done");
  endtask
  task automatic t_erase;
    run_op(PFH_OP_PROGRAM, 17'h02010, 8'h33);
    repeat (3) run_op(PFH_OP_READ, 17'h02010, 8'h00);
    chk(q, 8'h33);
    run_op(PFH_OP_SECTOR_ERASE, 17'h01FFF, 8'h00);
    chk(8'(wr_cnt), 8'h06);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    chk({6'h0, q[7:6]}, 8'h01);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    run_op(PFH_OP_READ, 17'h01234, 8'h00);
    chk(q, 8'hFF);
    run_op(PFH_OP_READ, 17'h02010, 8'h00);
    chk(q, 8'h33);
    run_op(PFH_OP_CHIP_ERASE, 17'h00000, 8'h00);
    chk(8'(wr_cnt), 8'h06);
    repeat (3) run_op(PFH_OP_READ, 17'h02010, 8'h00);
    chk(q, 8'hFF);
    $display("test erase done");
  endtask
  task automatic t_ident;
    for (int k = 0; k < 2; k++) begin
      run_op(PFH_OP_ID_ENTRY, 17'h00000, 8'h00);
      chk(8'(wr_cnt), 8'h03);
      run_op(PFH_OP_READ, ID_MAKER_ADDR, 8'h00);
      chk(q, MAKER);
      run_op(PFH_OP_READ, ID_PART_ADDR, 8'h00);
      chk(q, PART);
      run_op(k == 0 ? PFH_OP_ID_EXIT : PFH_OP_ID_EXIT_LONG, 17'h0ABCD, 8'h00);
      chk(8'(wr_cnt), k == 0 ? 8'h01 : 8'h03);
      run_op(PFH_OP_READ, ID_MAKER_ADDR, 8'h00);
      chk(q, 8'hFF);
    end
    $display("test ident done");
  endtask
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (5) @(negedge clk_sys);
    chk({4'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 8'h0E);
    chk({7'h0, req_ready}, 8'h01);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_program();
    t_erase();
    t_ident();
    conclude();
  end
endmodule
